// ===== hdl/hsum_consts.svh
// constants for the serial port divisor, receive view and character match block
// Notes on behaviour
// - match flag sits in bit 10 and reads 0 while matching is off.
// - break flag in bit 9 set for a break frame, clear otherwise.
// - bit 8 carries the sampled address bit of the received frame.
// - bits 7..0 give last character, or FIFO head when FIFOs are on.
// - received byte is valid only while the ready flag is 1.
// - extended read mirrors ready, tx empty, overrun and the head character's flags into upper bits; bit 11 reads 0.
// - peek read returns same contents, changes no status, no FIFO advance.
// - receive data read advances FIFO and drops ready when nothing remains.
// - sample clock is UART clock divided by divisor; baud is clock/(16*div).
// - UART clock is processor clock or the external clock when selected.
// - a zero divisor stops all reception and transmission.
// - autobaud loads the divisor field itself with the detected value.
// - divisor 1 is accepted, giving one sixteenth of the UART clock.
// - match registers hold odd character in 15..8, even in 7..0.
// - with match on, every character is compared and match flag set when any of the six characters equals it.
// - address matching also requires the pair's match address bit.
// - with match off, match fields are ignored and nothing compared.
`ifndef HSUM_CONSTS_SVH
`define HSUM_CONSTS_SVH
// register indices; byte address is four times the index
`define HSUM_IDX_CONTROL 12'h260
`define HSUM_IDX_STATUS 12'h262
`define HSUM_IDX_RXDATA 12'h26A
`define HSUM_IDX_PEEK 12'h26C
`define HSUM_IDX_DIVISOR 12'h26E
`define HSUM_IDX_MATCH01 12'h270
`define HSUM_IDX_MATCH23 12'h272
`define HSUM_IDX_MATCH45 12'h274
// control bit positions
`define HSUM_CTL_RX_MODE 0
`define HSUM_CTL_TX_MODE 1
`define HSUM_CTL_CMP_EN 2
`define HSUM_CTL_ABIT_EN 3
`define HSUM_CTL_PAIR_AB 4
`define HSUM_CTL_EXT_READ 7
`define HSUM_CTL_EXT_CLK 8
`define HSUM_CTL_AUTOBAUD 9
`define HSUM_CTL_FIFO_EN 10
`define HSUM_CTL_ADDR_FRAME 11
// status and receive view bit positions
`define HSUM_ST_RDR 15
`define HSUM_ST_TX_HOLD_EMPTY_FLAG 14
`define HSUM_ST_FER 13
`define HSUM_ST_OER 12
`define HSUM_ST_PER 11
`define HSUM_ST_MATCH 10
`define HSUM_ST_BRK 9
`define HSUM_ST_AB 8
// reset values
`define HSUM_RST_WORD 16'h0000
// receiver timing in 16x ticks, and receive fifo depth
`define HSUM_MID_TICK 4'h7
`define HSUM_LAST_TICK 4'hF
`define HSUM_FIFO_DEPTH 4
`endif

// ===== hdl/hsum_core.sv
// divisor, character match and receive data views of the high-speed serial port
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "hsum_consts.svh"
module hsum_core import hsum_pkg::*; (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial side
	input wire logic serial_rx_line,
	input wire logic external_uart_clock,
	// transmitter status from the same clock domain
	input wire logic tx_hold_empty_flag
);
	logic [31:0] prdata_reg;
	logic pready_reg;
	logic pslverr_reg;
	logic [15:0] port_control_a_reg;
	logic [15:0] divisor_value_reg;
	logic [15:0] match_reg [0:2];
	logic fer_st_reg, oer_st_reg, per_st_reg, match_st_reg, brk_st_reg;
	hsum_rx_entry_t fifo_mem [0:`HSUM_FIFO_DEPTH-1];
	logic [1:0] fifo_rd_reg, fifo_wr_reg;
	logic [2:0] fifo_cnt_reg;
	logic rx_s1_reg, rx_s2_reg, rx_s3_reg;
	logic ck_s1_reg, ck_s2_reg, ck_s3_reg;
	logic [15:0] baud_cnt_reg;
	logic [3:0] tick_cnt_reg;
	logic [3:0] bit_cnt_reg;
	logic [8:0] shift_reg;
	hsum_rx_state_t rx_state_reg;
	logic [19:0] ab_cnt_reg;
	logic ab_busy_reg;

	assign prdata = prdata_reg;
	assign pready = pready_reg;
	assign pslverr = pslverr_reg;

	// apb decode; registers sit at four times their index
	wire setup = psel & ~penable & ~pready_reg;
	wire done = psel & penable & pready_reg;
	wire [11:0] idx = paddr[13:2];
	wire hit_ctl = idx == `HSUM_IDX_CONTROL;
	wire hit_st = idx == `HSUM_IDX_STATUS;
	wire hit_rxd = idx == `HSUM_IDX_RXDATA;
	wire hit_peek = idx == `HSUM_IDX_PEEK;
	wire hit_div = idx == `HSUM_IDX_DIVISOR;
	wire hit_m0 = idx == `HSUM_IDX_MATCH01;
	wire hit_m1 = idx == `HSUM_IDX_MATCH23;
	wire hit_m2 = idx == `HSUM_IDX_MATCH45;
	wire mapped = (paddr[1:0] == 2'b00) && (paddr[31:14] == 18'h0)
		&& (hit_ctl | hit_st | hit_rxd | hit_peek | hit_div | hit_m0 | hit_m1 | hit_m2);
	wire wr_done = done & pwrite & ~pslverr_reg;
	wire pop = done & ~pwrite & hit_rxd & ~pslverr_reg & (fifo_cnt_reg != 3'h0);

	// control fields
	wire rx_mode = port_control_a_reg[`HSUM_CTL_RX_MODE];
	wire cmp_en = port_control_a_reg[`HSUM_CTL_CMP_EN];
	wire abit_en = port_control_a_reg[`HSUM_CTL_ABIT_EN];
	wire ext_read = port_control_a_reg[`HSUM_CTL_EXT_READ];
	wire ext_clk = port_control_a_reg[`HSUM_CTL_EXT_CLK];
	wire autobaud = port_control_a_reg[`HSUM_CTL_AUTOBAUD];
	wire fifo_en = port_control_a_reg[`HSUM_CTL_FIFO_EN];
	wire addr_frame = port_control_a_reg[`HSUM_CTL_ADDR_FRAME];

	// uart clock: processor clock, or sampled rising edge of the external one
	wire uart_tick = ext_clk ? (ck_s2_reg & ~ck_s3_reg) : 1'b1;
	wire div_zero = divisor_value_reg == 16'h0000;
	// zero divisor gives no ticks, so nothing moves on the line
	// at or above the end count, so a smaller divisor written mid-count cannot stall for a full wrap
	wire tick16 = uart_tick & ~div_zero & (baud_cnt_reg >= divisor_value_reg - 16'h0001);

	// receiver helpers
	wire rx_in = rx_s2_reg;
	wire [3:0] last_bit = addr_frame ? 4'h9 : 4'h8;
	wire [7:0] frame_data = addr_frame ? shift_reg[7:0] : shift_reg[8:1];
	wire frame_ab = addr_frame ? shift_reg[8] : 1'b0;
	wire stop_edge = tick16 && (rx_state_reg == HSUM_RX_STOP) && (tick_cnt_reg == `HSUM_LAST_TICK);
	wire frame_brk = (frame_data == 8'h00) && ~frame_ab && ~rx_in;
	wire [2:0] fifo_cap = fifo_en ? 3'(`HSUM_FIFO_DEPTH) : 3'h1;
	wire fifo_full = fifo_cnt_reg >= fifo_cap;
	wire push = stop_edge & ~fifo_full;
	wire overrun = stop_edge & fifo_full;

	// six comparators, one per match character
	wire [7:0] chr [0:5];
	wire [2:0] pair_ab = port_control_a_reg[`HSUM_CTL_PAIR_AB+2:`HSUM_CTL_PAIR_AB];
	wire [5:0] chr_eq;
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_cmp
			assign chr[gi] = (gi % 2 == 1) ? match_reg[gi/2][15:8] : match_reg[gi/2][7:0];
			assign chr_eq[gi] = (chr[gi] == frame_data) && (~abit_en || (pair_ab[gi/2] == frame_ab));
		end
	endgenerate
	wire frame_match = cmp_en & (|chr_eq);

	// receive data view shared by the normal and peek reads
	hsum_rx_entry_t head;
	assign head = fifo_mem[fifo_rd_reg];
	wire rx_ready_flag = fifo_cnt_reg != 3'h0;
	wire [7:0] view_flags = {rx_ready_flag, tx_hold_empty_flag, rx_ready_flag & head.framing_error_flag, rx_ready_flag & oer_st_reg, 1'b0,
		rx_ready_flag & head.match & cmp_en, rx_ready_flag & head.line_break_flag, rx_ready_flag & head.ab};
	wire [15:0] rx_view = {ext_read ? view_flags : 8'h00, rx_ready_flag ? head.data : 8'h00};
	wire [15:0] status_view = {rx_ready_flag, tx_hold_empty_flag, fer_st_reg, oer_st_reg, per_st_reg,
		match_st_reg & cmp_en, brk_st_reg, 9'h000};

	// read mux; peek uses the same view and has no side effect
	wire [15:0] rd_word = hit_ctl ? port_control_a_reg :
		hit_st ? status_view :
		(hit_rxd | hit_peek) ? rx_view :
		hit_div ? divisor_value_reg :
		hit_m0 ? match_reg[0] :
		hit_m1 ? match_reg[1] :
		hit_m2 ? match_reg[2] : 16'h0000;

	// apb answer: one access cycle, data latched in setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg <= setup;
			if (setup) begin
				pslverr_reg <= ~mapped;
				prdata_reg <= (mapped && !pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;
			end
		end
	end

	// control and match registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			port_control_a_reg <= `HSUM_RST_WORD;
			match_reg[0] <= `HSUM_RST_WORD;
			match_reg[1] <= `HSUM_RST_WORD;
			match_reg[2] <= `HSUM_RST_WORD;
		end else if (wr_done) begin
			if (hit_ctl) port_control_a_reg <= pwdata[15:0];
			if (hit_m0) match_reg[0] <= pwdata[15:0];
			if (hit_m1) match_reg[1] <= pwdata[15:0];
			if (hit_m2) match_reg[2] <= pwdata[15:0];
		end else if (ab_busy_reg && rx_s2_reg && !rx_s3_reg) begin
			// autobaud finishes on the start bit's rising edge
			port_control_a_reg[`HSUM_CTL_AUTOBAUD] <= 1'b0;
		end
	end

	// divisor: software writes, autobaud loads the measured start bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			divisor_value_reg <= `HSUM_RST_WORD;
		end else if (ab_busy_reg && rx_s2_reg && !rx_s3_reg) begin
			divisor_value_reg <= ab_cnt_reg[19:4];
		end else if (wr_done && hit_div) begin
			divisor_value_reg <= pwdata[15:0];
		end
	end

	// autobaud: count uart ticks while the start bit is low
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ab_cnt_reg <= 20'h00000;
			ab_busy_reg <= 1'b0;
		end else if (!autobaud) begin
			ab_busy_reg <= 1'b0;
		end else if (!rx_s2_reg && rx_s3_reg) begin
			ab_busy_reg <= 1'b1;
			// the first low cycle counts too, else the divisor comes out one short
			ab_cnt_reg <= {19'h00000, uart_tick};
		end else if (ab_busy_reg && !rx_s2_reg && uart_tick && ab_cnt_reg != 20'hFFFFF) begin
			ab_cnt_reg <= ab_cnt_reg + 20'h00001;
		end
	end

	// synchronisers for line and external clock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_s1_reg <= 1'b1;
			rx_s2_reg <= 1'b1;
			rx_s3_reg <= 1'b1;
			ck_s1_reg <= 1'b0;
			ck_s2_reg <= 1'b0;
			ck_s3_reg <= 1'b0;
		end else begin
			rx_s1_reg <= serial_rx_line;
			rx_s2_reg <= rx_s1_reg;
			rx_s3_reg <= rx_s2_reg;
			ck_s1_reg <= external_uart_clock;
			ck_s2_reg <= ck_s1_reg;
			ck_s3_reg <= ck_s2_reg;
		end
	end

	// baud divider making the 16x sample tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			baud_cnt_reg <= 16'h0000;
		end else if (div_zero || tick16) begin
			baud_cnt_reg <= 16'h0000;
		end else if (uart_tick) begin
			baud_cnt_reg <= baud_cnt_reg + 16'h0001;
		end
	end

	// receive framer; idle unless receive mode is on and autobaud is not running
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_state_reg <= HSUM_RX_IDLE;
			tick_cnt_reg <= 4'h0;
			bit_cnt_reg <= 4'h0;
			shift_reg <= 9'h000;
		end else if (!rx_mode || autobaud) begin
			rx_state_reg <= HSUM_RX_IDLE;
		end else if (tick16) begin
			tick_cnt_reg <= tick_cnt_reg + 4'h1;
			case (rx_state_reg)
				HSUM_RX_IDLE: begin
					tick_cnt_reg <= 4'h0;
					if (!rx_in) rx_state_reg <= HSUM_RX_START;
				end
				HSUM_RX_START: begin
					// mid start bit check rejects glitches
					if (tick_cnt_reg == `HSUM_MID_TICK) begin
						tick_cnt_reg <= 4'h0;
						bit_cnt_reg <= 4'h0;
						rx_state_reg <= rx_in ? HSUM_RX_IDLE : HSUM_RX_BITS;
					end
				end
				HSUM_RX_BITS: begin
					if (tick_cnt_reg == `HSUM_LAST_TICK) begin
						shift_reg <= {rx_in, shift_reg[8:1]};
						bit_cnt_reg <= bit_cnt_reg + 4'h1;
						if (bit_cnt_reg == last_bit - 4'h1) rx_state_reg <= HSUM_RX_STOP;
					end
				end
				HSUM_RX_STOP: begin
					if (tick_cnt_reg == `HSUM_LAST_TICK) rx_state_reg <= HSUM_RX_IDLE;
				end
				default: rx_state_reg <= HSUM_RX_IDLE;
			endcase
		end
	end

	// fifo storage has no reset; rdr masks whatever it holds
	always_ff @(posedge pclk) begin
		if (push) begin
			fifo_mem[fifo_wr_reg] <= '{framing_error_flag: ~rx_in, match: frame_match, line_break_flag: frame_brk,
				ab: frame_ab, data: frame_data};
		end
	end

	// receive fifo; depth one when fifos are off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fifo_rd_reg <= 2'h0;
			fifo_wr_reg <= 2'h0;
			fifo_cnt_reg <= 3'h0;
		end else begin
			if (push) fifo_wr_reg <= fifo_en ? fifo_wr_reg + 2'h1 : fifo_rd_reg;
			if (pop) fifo_rd_reg <= fifo_en ? fifo_rd_reg + 2'h1 : fifo_rd_reg;
			fifo_cnt_reg <= fifo_cnt_reg + {2'b00, push} - {2'b00, pop};
		end
	end

	// sticky status flags; a set wins over a write-one clear
	wire [15:0] clr = (wr_done && hit_st) ? pwdata[15:0] : 16'h0000;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fer_st_reg <= 1'b0;
			oer_st_reg <= 1'b0;
			per_st_reg <= 1'b0;
			match_st_reg <= 1'b0;
			brk_st_reg <= 1'b0;
		end else begin
			fer_st_reg <= (push & ~rx_in) | (fer_st_reg & ~clr[`HSUM_ST_FER]);
			oer_st_reg <= overrun | (oer_st_reg & ~clr[`HSUM_ST_OER]);
			per_st_reg <= per_st_reg & ~clr[`HSUM_ST_PER];
			match_st_reg <= (push & frame_match) | (match_st_reg & ~clr[`HSUM_ST_MATCH]);
			brk_st_reg <= (push & frame_brk) | (brk_st_reg & ~clr[`HSUM_ST_BRK]);
		end
	end

	// checks
	match_off_a: assert property (@(posedge pclk) disable iff (!presetn) !cmp_en |-> !rx_view[10])
		else $error("match bit set while matching is off");
	zero_div_a: assert property (@(posedge pclk) disable iff (!presetn) div_zero |-> !tick16 && !push)
		else $error("activity with zero divisor");
	peek_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		done && hit_peek && !push |=> $stable(fifo_cnt_reg) && $stable(fifo_rd_reg))
		else $error("peek read changed the fifo");
	pop_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
		pop && !push && fifo_cnt_reg == 3'h1 |=> !rx_ready_flag)
		else $error("ready stayed after last read");
	div_one_a: assert property (@(posedge pclk) disable iff (!presetn)
		divisor_value_reg == 16'h0001 && !ext_clk |-> tick16)
		else $error("divisor one not every clock");
	rdr_view_a: assert property (@(posedge pclk) disable iff (!presetn) !rx_ready_flag |-> rx_view[7:0] == 8'h00)
		else $error("data shown without ready");
	match_store_a: assert property (@(posedge pclk) disable iff (!presetn)
		push && frame_match |=> match_st_reg)
		else $error("match flag not set");
	ext_mirror_a: assert property (@(posedge pclk) disable iff (!presetn)
		ext_read |-> rx_view[15] == rx_ready_flag && rx_view[14] == tx_hold_empty_flag)
		else $error("extended bits not mirrored");
	pair_ab_a: assert property (@(posedge pclk) disable iff (!presetn)
		abit_en && cmp_en && pair_ab == 3'b000 && frame_ab |-> !frame_match)
		else $error("address bit ignored in match");
	ab_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		ab_busy_reg && rx_s2_reg && !rx_s3_reg && !wr_done |=> divisor_value_reg == $past(ab_cnt_reg[19:4]))
		else $error("autobaud divisor not loaded");
	// status bits 13..8 of an empty view must read zero
	rdr_flags_a: assert property (@(posedge pclk) disable iff (!presetn)
		!rx_ready_flag |-> rx_view[13:8] == 6'h00)
		else $error("status shown without ready");
	ext_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ext_read |-> rx_view[15:8] == 8'h00)
		else $error("upper bits shown without extended read");
	brk_store_a: assert property (@(posedge pclk) disable iff (!presetn)
		push && frame_brk |=> brk_st_reg)
		else $error("break flag not set");
	ab_plain_a: assert property (@(posedge pclk) disable iff (!presetn)
		!addr_frame |-> !frame_ab)
		else $error("address bit without address frames");
	pop_adv_a: assert property (@(posedge pclk) disable iff (!presetn)
		pop && fifo_en |=> fifo_rd_reg == $past(fifo_rd_reg) + 2'h1)
		else $error("fifo not advanced by read");
	cmp_off_a: assert property (@(posedge pclk) disable iff (!presetn)
		!cmp_en |-> !frame_match)
		else $error("match with matching off");
	push_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		push |=> rx_ready_flag)
		else $error("stored character not ready");
	fifo_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
		fifo_cnt_reg <= 3'h4)
		else $error("fifo count beyond depth");
	// the bus answer is a single cycle pulse
	apb_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready_reg |=> !pready_reg)
		else $error("ready held too long");
endmodule // hsum_core

// ===== hdl/hsum_pkg.sv
// types shared by the serial port divisor and match block
package hsum_pkg;
	typedef enum logic [1:0] {
		HSUM_RX_IDLE = 2'b00,
		HSUM_RX_START = 2'b01,
		HSUM_RX_BITS = 2'b10,
		HSUM_RX_STOP = 2'b11
	} hsum_rx_state_t;
	typedef struct packed {
		logic framing_error_flag;
		logic match;
		logic line_break_flag;
		logic ab;
		logic [7:0] data;
	} hsum_rx_entry_t;
endpackage

// ===== tb/hs_uart_baud_and_char_match_tb_top.sv
// testbench for the divisor, character match and receive views
`timescale 1ns/1ps
`include "hsum_consts.svh"
module hs_uart_baud_and_char_match_tb_top;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata;
	logic pready, pslverr, rx_line, ext_clk = 1'b0, ext_run = 1'b0, tx_hold_empty_flag_q = 1'b1;
	int fails = 0, checks_done = 0;
	logic [31:0] rd;
	logic err;
	// control words built from the designer's bit positions
	localparam logic [15:0] RX = 16'h0001 << `HSUM_CTL_RX_MODE, CMP = 16'h0001 << `HSUM_CTL_CMP_EN;
	localparam logic [15:0] EXR = 16'h0001 << `HSUM_CTL_EXT_READ, ADDR_BIT_ENABLE = 16'h0001 << `HSUM_CTL_ABIT_EN;
	localparam logic [15:0] P0AB = 16'h0001 << `HSUM_CTL_PAIR_AB, AF = 16'h0001 << `HSUM_CTL_ADDR_FRAME;
	localparam logic [15:0] FIFO = 16'h0001 << `HSUM_CTL_FIFO_EN, EXTC = 16'h0001 << `HSUM_CTL_EXT_CLK;
	localparam logic [15:0] ABD = 16'h0001 << `HSUM_CTL_AUTOBAUD;
	// one field per row, one case per position: control, character, address bit, stop level, expected peek
	logic [15:0] t_ctl [8] = '{RX|EXR|CMP, RX|EXR|CMP, RX|EXR, RX|CMP, RX|EXR|CMP|AF|ADDR_BIT_ENABLE|P0AB,
		RX|EXR|CMP|AF|ADDR_BIT_ENABLE|P0AB, RX|EXR, RX|EXR|CMP};
	logic [7:0] t_ch [8] = '{8'h13, 8'h22, 8'h13, 8'h13, 8'h11, 8'h11, 8'h00, 8'h04};
	logic t_ab [8] = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	logic t_stop [8] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
	logic [15:0] t_exp [8] = '{16'hC413, 16'hC022, 16'hC013, 16'h0013, 16'hC011, 16'hC511, 16'hE200, 16'hC404};

	hsum_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.serial_rx_line(rx_line), .external_uart_clock(ext_clk), .tx_hold_empty_flag(tx_hold_empty_flag_q));
	hsum_serial_src src (.pclk(pclk), .serial_rx_line(rx_line));

	// 125 MHz system clock; external clock at an unrelated 46 ns period
	always #4 pclk = ~pclk;
	always #23 ext_clk = ext_run ? ~ext_clk : 1'b0;

	// one apb transfer; request held until pready is seen at a rising edge
	task automatic apb(input logic wr, input logic [11:0] idx, input logic [15:0] wd, output logic [31:0] r,
		output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {18'h0, idx, 2'b00};
		pwdata <= {16'h0, wd};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			fails++;
			$display("wrong value at %0t: no bus answer", $time);
		end
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	task automatic wr(input logic [11:0] idx, input logic [15:0] d);
		apb(1'b1, idx, d, rd, err);
	endtask
	task automatic rd_chk(input logic [11:0] idx, input logic [15:0] exp, input string what);
		apb(1'b0, idx, 16'h0, rd, err);
		chk(rd, {16'h0, exp}, what);
	endtask
	// frame plus one spare bit time for the stop tick and synchroniser
	task automatic frame(input logic [7:0] d, input logic ab, input logic nine, input logic stp, input int bitc);
		src.send(d, ab, nine, stp, bitc);
		repeat (bitc) @(posedge pclk);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// watchdog: the whole run needs well under 20000 cycles
	initial begin
		#160000;
		fails++;
		tally_and_finish();
	end

	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd_chk(`HSUM_IDX_DIVISOR, 16'h0000, "divisor reset");
		rd_chk(`HSUM_IDX_MATCH01, 16'h0000, "match01 reset");
		rd_chk(`HSUM_IDX_MATCH23, 16'h0000, "match23 reset");
		rd_chk(`HSUM_IDX_MATCH45, 16'h0000, "match45 reset");
		apb(1'b0, 12'h3F0, 16'h0, rd, err);
		chk({31'h0, err}, 32'h1, "unmapped error");
		wr(`HSUM_IDX_DIVISOR, 16'hA5C3);
		rd_chk(`HSUM_IDX_DIVISOR, 16'hA5C3, "divisor readback");
		$display("test registers done");
		// zero divisor: a frame on the line must not be taken
		wr(`HSUM_IDX_DIVISOR, 16'h0000);
		wr(`HSUM_IDX_CONTROL, RX|EXR);
		frame(8'h11, 1'b0, 1'b0, 1'b1, 16);
		rd_chk(`HSUM_IDX_PEEK, 16'h4000, "zero divisor idle");
		$display("test zero divisor done");
		// fastest divisor; unused match slots filled with a wanted duplicate
		wr(`HSUM_IDX_CONTROL, 16'h0000);
		wr(`HSUM_IDX_DIVISOR, 16'h0001);
		wr(`HSUM_IDX_MATCH01, 16'h1311);
		wr(`HSUM_IDX_MATCH23, 16'h0404);
		wr(`HSUM_IDX_MATCH45, 16'h0404);
		for (int i = 0; i < 8; i++) begin
			wr(`HSUM_IDX_CONTROL, t_ctl[i]);
			frame(t_ch[i], t_ab[i], t_ctl[i][`HSUM_CTL_ADDR_FRAME], t_stop[i], 16);
			rd_chk(`HSUM_IDX_PEEK, t_exp[i], "peek view");
			rd_chk(`HSUM_IDX_PEEK, t_exp[i], "peek repeat");
			rd_chk(`HSUM_IDX_RXDATA, t_exp[i], "data view");
		end
		rd_chk(`HSUM_IDX_PEEK, 16'h4000, "flags zero when empty");
		wr(`HSUM_IDX_STATUS, 16'h3E00);
		rd_chk(`HSUM_IDX_STATUS, 16'h4000, "status cleared");
		$display("test match and flags done");
		// fifo order, then transmit-empty mirrored live
		wr(`HSUM_IDX_CONTROL, RX|EXR|FIFO);
		frame(8'h31, 1'b0, 1'b0, 1'b1, 16);
		frame(8'h32, 1'b0, 1'b0, 1'b1, 16);
		rd_chk(`HSUM_IDX_PEEK, 16'hC031, "fifo head");
		rd_chk(`HSUM_IDX_RXDATA, 16'hC031, "fifo pop one");
		rd_chk(`HSUM_IDX_RXDATA, 16'hC032, "fifo pop two");
		@(posedge pclk);
		tx_hold_empty_flag_q <= 1'b0;
		rd_chk(`HSUM_IDX_PEEK, 16'h0000, "tx empty low");
		tx_hold_empty_flag_q <= 1'b1;
		$display("test fifo done");
		// divisor 3: 48 clocks per bit
		wr(`HSUM_IDX_CONTROL, 16'h0000);
		wr(`HSUM_IDX_DIVISOR, 16'h0003);
		wr(`HSUM_IDX_CONTROL, RX|EXR);
		frame(8'h5A, 1'b0, 1'b0, 1'b1, 48);
		rd_chk(`HSUM_IDX_RXDATA, 16'hC05A, "divisor three");
		// autobaud from divisor 1: a 48 clock start bit measures divisor 3
		wr(`HSUM_IDX_CONTROL, 16'h0000);
		wr(`HSUM_IDX_DIVISOR, 16'h0001);
		wr(`HSUM_IDX_CONTROL, RX|EXR|ABD);
		frame(8'hFF, 1'b0, 1'b0, 1'b1, 48);
		rd_chk(`HSUM_IDX_DIVISOR, 16'h0003, "autobaud divisor");
		rd_chk(`HSUM_IDX_CONTROL, RX|EXR, "autobaud self clear");
		// external clock, divisor 1: 16 edges of 46 ns per bit
		wr(`HSUM_IDX_CONTROL, 16'h0000);
		wr(`HSUM_IDX_DIVISOR, 16'h0001);
		ext_run <= 1'b1;
		wr(`HSUM_IDX_CONTROL, RX|EXR|EXTC);
		frame(8'hA6, 1'b0, 1'b0, 1'b1, 92);
		rd_chk(`HSUM_IDX_RXDATA, 16'hC0A6, "external clock");
		$display("test baud sources done");
		tally_and_finish();
	end
endmodule // hs_uart_baud_and_char_match_tb_top

// ===== tb/hsum_serial_src.sv
// remote serial transmitter model driving the port's receive line
`timescale 1ns/1ps
module hsum_serial_src (
	// clock
	input wire logic pclk,
	// serial line toward the port
	output logic serial_rx_line
);
	logic line_q = 1'b1;
	// line idles high, as a released uart line does
	assign serial_rx_line = line_q;

	// start, eight data bits lsb first, optional address bit, one stop bit
	task automatic send(input logic [7:0] d, input logic ab, input logic nine, input logic stop_lvl, input int bitc);
		logic [10:0] bits;
		int n;
		bits = nine ? {stop_lvl, ab, d, 1'b0} : {1'b1, stop_lvl, d, 1'b0};
		n = nine ? 11 : 10;
		for (int i = 0; i < n; i++) begin
			@(posedge pclk);
			line_q <= bits[i];
			repeat (bitc - 1) @(posedge pclk);
		end
		@(posedge pclk);
		line_q <= 1'b1; // back to idle even after a break frame
	endtask
endmodule // hsum_serial_src
